//--- acc_host.sv
`timescale 1ns/1ps
`default_nettype none
module acc_host (
  // Clock and pin mode: 0 high, 1 toggling, 2 low
  input  wire logic       mclk,
  input  wire logic [1:0] drive,
  // Hardware trigger pin
  output logic            trigger_input_pin
);
  // Idle level high, so no trigger is seen until one is wanted
  always_ff @(posedge mclk) begin
    trigger_input_pin <= (drive == 2'h1) ? !trigger_input_pin : (drive != 2'h2);
  end
endmodule : acc_host
`default_nettype wire

//--- acc_pkg.sv
`default_nettype none
package acc_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_AVG       = 8'h68;
  localparam logic [7:0] ADDR_STATUS    = 8'h6A;
  localparam logic [7:0] ADDR_PIN_CFG   = 8'h6B;
  localparam logic [7:0] ADDR_SOFT_TRIG = 8'h6C;
  localparam logic [7:0] ADDR_LP        = 8'h6E;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_AVG       = 8'h61;
  localparam logic [7:0] RST_PIN_CFG   = 8'h00;
  localparam logic [7:0] RST_SOFT_TRIG = 8'h01;
  localparam logic [7:0] RST_LP        = 8'h88;
  localparam logic [7:0] RST_ZERO      = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int OFS_AVG_LSB   = 4;
  localparam int LIN_AVG_LSB   = 0;
  localparam int STAT_CODE_LSB = 2;
  localparam int STAT_STOP_BIT = 1;
  localparam int STAT_DONE_BIT = 0;
  localparam int PIN_SEL_LSB   = 1;
  localparam int PIN_HWTRG_BIT = 0;
  localparam int SOFT_TRG_BIT  = 0;
  localparam int LP_SLEEP_LSB  = 5;
  localparam int LP_WAKE_LSB   = 3;
  localparam int LP_TWAKE_BIT  = 1;
  localparam int LOW_POWER_BACKGROUND_ENABLE_BIT     = 0;

  // ----------------------------------------
  // Status pin selector codes
  // ----------------------------------------
  localparam logic [1:0] PSEL_DONE  = 2'h0;
  localparam logic [1:0] PSEL_STOP  = 2'h1;
  localparam logic [1:0] PSEL_ALARM = 2'h2;

  // ----------------------------------------
  // Low-power timing: (2^k + 1) x unit periods
  // ----------------------------------------
  localparam int LP_UNIT_PERIODS = 256;
  localparam int CNT_W           = 48;

  typedef enum logic [1:0] {
    ACC_LP_IDLE,
    ACC_LP_SLEEP,
    ACC_LP_SETTLE,
    ACC_LP_CAL
  } acc_lp_state_t;
endpackage : acc_pkg
`default_nettype wire

//--- acc_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Offset averaging field bits 6:4, reset 6
// - Linearity averaging field bits 2:0, reset 1
// - Status read-only: code 4:2, 7:5 zero
// - Stopped flag set on halt, cleared on resume
// - Background off: stopped set on foreground end
// - Done bit set when foreground finished/skipped
// - Pin selector: done, stopped, alarm, low
// - Select 0: software trigger, pin ignored
// - Select 1: trigger pin, software bit ignored
// - Software trigger bit resets to 1
// - Low-power register resets 0x88 with fields
// - Low-power needs enable and background enable
// - Trigger-wake mode: sleep until trigger low
// - Sleep time (2^k+1) x 256 periods
// - Settle time (2^k+1) x 256 before calibrate
module acc_regs
  import acc_pkg::*;
#(
  parameter int UNIT_PERIODS = LP_UNIT_PERIODS
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // Register port
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  // Calibration engine status
  input  wire logic       background_calibration_enable,
  input  wire logic       fg_start,
  input  wire logic       fg_complete,
  input  wire logic       bg_halted,
  input  wire logic       bg_resumed,
  input  wire logic [2:0] cal_status_code,
  input  wire logic       alarm,
  input  wire logic       core_cal_done,
  // Averaging levels to the engine
  output logic      [2:0] offset_averaging_level,
  output logic      [2:0] linearity_averaging_level,
  // Pins
  input  wire logic       trigger_input_pin,
  output logic            status_output_pin,
  output logic            calibration_trigger,
  // Low-power core control
  output logic            core_sleep,
  output logic            core_cal_start
);

  // Register map:
  //   averaging      offset and linearity levels, reserved bits kept
  //   status         read only, engine code and two flags
  //   pin config     status pin source and trigger source
  //   soft trigger   stand-in for the trigger pin
  //   low power      sleep and settle codes, wake mode, enable
  // Writes to unmapped offsets vanish; reads of them return zero.
  // Port is a simple parallel strobe interface: one access per strobe.
  // Status pin and read data both come from flip-flops.
  // Trigger selection is combinational so the engine sees the pin
  // with no added delay.

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Host-writable registers
  logic [7:0]       avg_ff;
  logic [7:0]       pin_cfg_ff;
  logic [7:0]       soft_trig_ff;
  logic [7:0]       lp_ff;
  // Status flags and the registered pin
  logic             foreground_finished_flag_ff;
  logic             stopped_ff;
  logic             pin_ff;
  logic [2:0]       code_ff;
  // Read answer
  logic [7:0]       rdata_ff;
  logic             rvalid_ff;
  // Low-power sequencer; counter wide enough for the longest sleep
  acc_lp_state_t    state_ff;
  logic [CNT_W-1:0] cnt_ff;

  // Delay in cycles for an exponent
  // Width covers k up to 33 times the unit; no overflow at the top code
  // Codes change only on host writes, so the result is quasi static
  function automatic logic [CNT_W-1:0] lp_cycles(input logic [5:0] k);
    logic [CNT_W-1:0] base;
    base = (CNT_W'(1) << k) + CNT_W'(1);
    return base * CNT_W'(UNIT_PERIODS);
  endfunction : lp_cycles

  // ----------------------------------------
  // Decode and selection
  // ----------------------------------------
  // One write strobe per host-writable register; status has none
  wire logic       wr_avg    = reg_wr && (reg_addr == ADDR_AVG);
  wire logic       wr_pin    = reg_wr && (reg_addr == ADDR_PIN_CFG);
  wire logic       wr_soft   = reg_wr && (reg_addr == ADDR_SOFT_TRIG);
  wire logic       wr_lp     = reg_wr && (reg_addr == ADDR_LP);
  // Fields of the configuration registers
  wire logic [1:0] pin_sel   = pin_cfg_ff[PIN_SEL_LSB +: 2];
  wire logic       hw_sel    = pin_cfg_ff[PIN_HWTRG_BIT];
  wire logic [2:0] sleep_cd  = lp_ff[LP_SLEEP_LSB +: 3];
  wire logic [1:0] wake_cd   = lp_ff[LP_WAKE_LSB +: 2];
  wire logic       trig_wake = lp_ff[LP_TWAKE_BIT];
  // Enable bit alone does nothing without background calibration
  wire logic       lp_active = lp_ff[LOW_POWER_BACKGROUND_ENABLE_BIT] && background_calibration_enable;
  // Sleep exponents 3,15,18..33; wake exponents 3,18,21,24
  wire logic [5:0] sleep_k   = (sleep_cd == 3'h0) ? 6'h03 : 6'(12 + 3 * sleep_cd);
  wire logic [5:0] wake_k    = (wake_cd == 2'h0) ? 6'h03 : 6'(15 + 3 * wake_cd);
  wire logic [CNT_W-1:0] sleep_n = lp_cycles(sleep_k);
  wire logic [CNT_W-1:0] wake_n  = lp_cycles(wake_k);
  // Completion and skip arrive on the same strobe
  wire logic       fg_end    = fg_complete;
  // With background off, the end of foreground also stops it
  wire logic       bg_stop_ev = bg_halted || (!background_calibration_enable && fg_end);

  // Averaging levels straight from the register fields
  assign offset_averaging_level    = avg_ff[OFS_AVG_LSB +: 3];
  assign linearity_averaging_level = avg_ff[LIN_AVG_LSB +: 3];
  // Only the selected trigger source reaches the engine
  assign calibration_trigger = hw_sel ? trigger_input_pin
                                      : soft_trig_ff[SOFT_TRG_BIT];
  // Remaining outputs from flip-flops
  assign status_output_pin   = pin_ff;
  assign reg_rdata           = rdata_ff;
  assign reg_rvalid          = rvalid_ff;
  assign core_sleep          = (state_ff == ACC_LP_SLEEP);

  // Status pin mux, registered to keep the pin glitch free
  // Costs one cycle of lag on the pin against the flags
  logic nxt_pin;
  always_comb begin
    case (pin_sel)
      PSEL_DONE:  nxt_pin = foreground_finished_flag_ff;
      PSEL_STOP:  nxt_pin = stopped_ff;
      PSEL_ALARM: nxt_pin = alarm;
      // Code 3 parks the pin low
      default:    nxt_pin = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Writable registers, reserved bits kept
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      // Averaging resets to offset 6, linearity 1
      avg_ff       <= RST_AVG;
      pin_cfg_ff   <= RST_PIN_CFG;
      soft_trig_ff <= RST_SOFT_TRIG;
      lp_ff        <= RST_LP;
    end else begin
      // Reserved bits are stored as written and read back
      if (wr_avg) begin
        avg_ff <= reg_wdata;
      end
      if (wr_pin) begin
        pin_cfg_ff <= reg_wdata;
      end
      if (wr_soft) begin
        soft_trig_ff <= reg_wdata;
      end
      // Low-power codes take effect on the next sequencer step
      if (wr_lp) begin
        lp_ff <= reg_wdata;
      end
    end
  end

  // ----------------------------------------
  // Status flags; set wins over clear
  // ----------------------------------------
  // Pulses from the engine are one cycle wide
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      foreground_finished_flag_ff <= 1'b0;
      stopped_ff <= 1'b0;
      code_ff    <= 3'h0;
      pin_ff     <= 1'b0;
    end else begin
      // Code copied each cycle; host writes never reach it
      code_ff    <= cal_status_code;
      // Start clears done, but a same-cycle end keeps it set
      foreground_finished_flag_ff <= fg_end || (foreground_finished_flag_ff && !fg_start);
      // Resume clears stopped; a same-cycle halt keeps it set
      stopped_ff <= bg_stop_ev || (stopped_ff && !bg_resumed);
      pin_ff     <= nxt_pin;
    end
  end

  // ----------------------------------------
  // Read path, one cycle latency
  // ----------------------------------------
  // Data held until the next read so a slow host can still take it
  // Unmapped offsets read zero rather than the last value
  logic [7:0] nxt_rdata;
  always_comb begin
    case (reg_addr)
      ADDR_AVG:       nxt_rdata = avg_ff;
      ADDR_STATUS:    nxt_rdata = {3'h0, code_ff, stopped_ff, foreground_finished_flag_ff};
      ADDR_PIN_CFG:   nxt_rdata = pin_cfg_ff;
      ADDR_SOFT_TRIG: nxt_rdata = soft_trig_ff;
      ADDR_LP:        nxt_rdata = lp_ff;
      default:        nxt_rdata = RST_ZERO;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdata_ff  <= RST_ZERO;
      rvalid_ff <= 1'b0;
    end else begin
      // rvalid follows the strobe by one cycle
      rvalid_ff <= reg_rd;
      if (reg_rd) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // ----------------------------------------
  // Low-power sleep / settle / calibrate sequencer
  // ----------------------------------------
  // IDLE  : low power off, counter cleared
  // SLEEP : core asleep; timed, or until the trigger goes low
  // SETTLE: core awake, waiting for it to settle
  // CAL   : one start pulse, then wait for the engine's done
  // Counter counts cycles spent in SLEEP and SETTLE; IDLE and CAL hold it at zero.
  // Dropping either enable aborts the sequence at once, so a core
  // may wake mid-sleep; the engine must tolerate that.
  acc_lp_state_t    nxt_state;
  logic [CNT_W-1:0] nxt_cnt;
  logic             nxt_start;
  always_comb begin
    // Defaults: hold state, count up, no start
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff + CNT_W'(1);
    nxt_start = 1'b0;
    case (state_ff)
      ACC_LP_IDLE: begin
        // Wait here until low power is allowed
        nxt_cnt = '0;
        if (lp_active) nxt_state = ACC_LP_SLEEP;
      end
      ACC_LP_SLEEP: begin
        // Trigger mode wakes on a low trigger, else a timed sleep
        if (trig_wake ? !calibration_trigger : (cnt_ff + CNT_W'(1) >= sleep_n)) begin
          nxt_state = ACC_LP_SETTLE;
          nxt_cnt   = '0;
        end
      end
      ACC_LP_SETTLE: begin
        // Settle length from the wake code
        if (cnt_ff + CNT_W'(1) >= wake_n) begin
          nxt_state = ACC_LP_CAL;
          nxt_start = 1'b1;
          nxt_cnt   = '0;
        end
      end
      ACC_LP_CAL: begin
        // Engine owns the core until it reports done
        nxt_cnt = '0;
        if (core_cal_done) nxt_state = ACC_LP_SLEEP;
      end
      default: nxt_state = ACC_LP_IDLE;
    endcase
    // Leaving low-power mode drops the sequence at once
    // Overrides every state above
    if (!lp_active) begin
      nxt_state = ACC_LP_IDLE;
      nxt_start = 1'b0;
      nxt_cnt   = '0;
    end
  end

  // Sequencer registers; start pulse registered to stay glitch free
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      // Start in IDLE: no core sleeps out of reset
      state_ff       <= ACC_LP_IDLE;
      cnt_ff         <= '0;
      core_cal_start <= 1'b0;
    end else begin
      state_ff       <= nxt_state;
      cnt_ff         <= nxt_cnt;
      core_cal_start <= nxt_start;
    end
  end

endmodule : acc_regs

`default_nettype wire

//--- acc_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module acc_regs_props
  import acc_pkg::*;
(
  // Clock, reset and register port
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Engine status and pins
  input wire logic       background_calibration_enable,
  input wire logic       fg_complete,
  input wire logic       bg_halted,
  input wire logic       alarm,
  input wire logic [2:0] offset_averaging_level,
  input wire logic [2:0] linearity_averaging_level,
  input wire logic       trigger_input_pin,
  input wire logic       status_output_pin,
  input wire logic       calibration_trigger
);
  logic [3:0] cfg_ff;
  // Shadow {soft bit, pin select, source}: pin checks need no internals
  always_ff @(posedge mclk) begin
    if (!rstn) cfg_ff <= 4'h8;
    else if (reg_wr && reg_addr == ADDR_PIN_CFG) cfg_ff[2:0] <= reg_wdata[2:0];
    else if (reg_wr && reg_addr == ADDR_SOFT_TRIG) cfg_ff[3] <= reg_wdata[0];
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_avg_levels_set: assert property (reg_wr && reg_addr == ADDR_AVG |=>
    {offset_averaging_level, linearity_averaging_level} == $past({reg_wdata[6:4], reg_wdata[2:0]}))
    else $error("averaging levels wrong");
  a_status_rsvd_zero: assert property (reg_rd && reg_addr == ADDR_STATUS |=>
    reg_rdata[7:5] == 3'h0) else $error("status reserved bits set");
  a_trig_hw: assert property (cfg_ff[0] |->
    calibration_trigger == trigger_input_pin) else $error("trigger not from pin");
  a_trig_soft: assert property (!cfg_ff[0] |->
    calibration_trigger == cfg_ff[3]) else $error("trigger not from soft bit");
  a_pin_alarm: assert property (cfg_ff[2:1] == PSEL_ALARM |=>
    status_output_pin == $past(alarm)) else $error("pin not alarm");
  a_pin_low: assert property (cfg_ff[2:1] == 2'h3 |=> !status_output_pin)
    else $error("pin not low");
  a_done_pin: assert property (fg_complete && cfg_ff[2:1] == PSEL_DONE
    ##1 cfg_ff[2:1] == PSEL_DONE |=> status_output_pin) else $error("done not on pin");
  a_stop_pin: assert property ((bg_halted || fg_complete && !background_calibration_enable)
    && cfg_ff[2:1] == PSEL_STOP ##1 cfg_ff[2:1] == PSEL_STOP |=> status_output_pin)
    else $error("stopped not on pin");
endmodule : acc_regs_props
bind acc_regs acc_regs_props acc_regs_props_i (
  .mclk                          (mclk),
  .rstn                          (rstn),
  .reg_wr                        (reg_wr),
  .reg_rd                        (reg_rd),
  .reg_addr                      (reg_addr),
  .reg_wdata                     (reg_wdata),
  .reg_rdata                     (reg_rdata),
  .background_calibration_enable (background_calibration_enable),
  .fg_complete                   (fg_complete),
  .bg_halted                     (bg_halted),
  .alarm                         (alarm),
  .offset_averaging_level        (offset_averaging_level),
  .linearity_averaging_level     (linearity_averaging_level),
  .trigger_input_pin             (trigger_input_pin),
  .status_output_pin             (status_output_pin),
  .calibration_trigger           (calibration_trigger)
);
`default_nettype wire

//--- acc_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("ERROR %0t: got %h, expected %h", $time, a, e); end end
module acc_regs_tb
  import acc_pkg::*;
;
  // Stimulus and observed ports
  logic       mclk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, alarm = 1'b0;
  logic       background_calibration_enable = 1'b0, core_cal_done = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [3:0] ev = 4'h0;
  logic [2:0] cal_status_code = 3'h0, offset_averaging_level, linearity_averaging_level;
  logic [1:0] drive = 2'h0;
  logic       reg_rvalid, trigger_input_pin, status_output_pin, calibration_trigger;
  logic       core_sleep, core_cal_start;
  wire logic  fg_start, fg_complete, bg_halted, bg_resumed;
  int         bad_count = 0, n_checks = 0, n;
  assign {fg_start, fg_complete, bg_halted, bg_resumed} = ev;
  // 200 MHz clock
  always #2.5 mclk = ~mclk;
  acc_regs #(.UNIT_PERIODS(1)) acc_regs_i (
    .mclk                          (mclk),
    .rstn                          (rstn),
    .reg_wr                        (reg_wr),
    .reg_rd                        (reg_rd),
    .reg_addr                      (reg_addr),
    .reg_wdata                     (reg_wdata),
    .reg_rdata                     (reg_rdata),
    .reg_rvalid                    (reg_rvalid),
    .background_calibration_enable (background_calibration_enable),
    .fg_start                      (fg_start),
    .fg_complete                   (fg_complete),
    .bg_halted                     (bg_halted),
    .bg_resumed                    (bg_resumed),
    .cal_status_code               (cal_status_code),
    .alarm                         (alarm),
    .core_cal_done                 (core_cal_done),
    .offset_averaging_level        (offset_averaging_level),
    .linearity_averaging_level     (linearity_averaging_level),
    .trigger_input_pin             (trigger_input_pin),
    .status_output_pin             (status_output_pin),
    .calibration_trigger           (calibration_trigger),
    .core_sleep                    (core_sleep),
    .core_cal_start                (core_cal_start)
  );
  acc_host acc_host_i (
    .mclk              (mclk),
    .drive             (drive),
    .trigger_input_pin (trigger_input_pin)
  );
  // Register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // Register read, answer taken a cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    `CHK(reg_rvalid, 1'b1)
    `CHK(reg_rdata, e)
  endtask : rd
  // One-cycle engine event {start, complete, halted, resumed}
  task automatic pulse(input logic [3:0] v);
    @(posedge mclk);
    ev <= v;
    @(posedge mclk);
    ev <= 4'h0;
  endtask : pulse
  // Bounded wait for settle end, then the engine reports done
  task automatic cal_core();
    n = 0;
    while (core_cal_start !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    @(posedge mclk);
    core_cal_done <= 1'b1;
    @(posedge mclk);
    core_cal_done <= 1'b0;
  endtask : cal_core
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  // Watchdog: the run needs well under 2 us
  initial begin
    #20us;
    bad_count++;
    finish_test();
  end
  // ------------------------------
  // Test sequence
  // ------------------------------
  initial begin
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    rd(ADDR_AVG, RST_AVG);
    rd(ADDR_STATUS, RST_ZERO);
    rd(ADDR_PIN_CFG, RST_PIN_CFG);
    rd(ADDR_SOFT_TRIG, RST_SOFT_TRIG);
    rd(ADDR_LP, RST_LP);
    rd(8'h69, RST_ZERO);
    `CHK(calibration_trigger, 1'b1)
    $display("reset test done");
    wr(ADDR_AVG, 8'hDA);
    rd(ADDR_AVG, 8'hDA);
    `CHK({offset_averaging_level, linearity_averaging_level}, 6'h2A)
    @(posedge mclk) cal_status_code <= 3'h5;
    pulse(4'h4);
    wr(ADDR_STATUS, 8'hFF);
    rd(ADDR_STATUS, 8'h17);
    pulse(4'h8);
    rd(ADDR_STATUS, 8'h16);
    @(posedge mclk) background_calibration_enable <= 1'b1;
    pulse(4'h1);
    rd(ADDR_STATUS, 8'h14);
    pulse(4'h2);
    rd(ADDR_STATUS, 8'h16);
    $display("status test done");
    @(posedge mclk) alarm <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_PIN_CFG, 8'(s << 1));
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      `CHK(status_output_pin, 1'(s == 1 || s == 2))
    end
    wr(ADDR_PIN_CFG, 8'h02);
    pulse(4'h2);
    $display("pin test done");
    wr(ADDR_PIN_CFG, 8'h01);
    @(posedge mclk) drive <= 2'h1;
    repeat (4) begin
      @(negedge mclk);
      `CHK(calibration_trigger, trigger_input_pin)
    end
    wr(ADDR_SOFT_TRIG, 8'h00);
    wr(ADDR_PIN_CFG, 8'h00);
    repeat (4) begin
      @(negedge mclk);
      `CHK(calibration_trigger, 1'b0)
    end
    $display("trigger test done");
    wr(ADDR_SOFT_TRIG, 8'h01);
    wr(ADDR_LP, 8'h01);
    cal_core();
    `CHK(n >= 18 && n <= 21, 1'b1)
    wr(ADDR_LP, 8'h03);
    repeat (20) @(negedge mclk);
    `CHK(core_sleep, 1'b1)
    wr(ADDR_SOFT_TRIG, 8'h00);
    repeat (3) @(negedge mclk);
    `CHK(core_sleep, 1'b0)
    wr(ADDR_SOFT_TRIG, 8'h01);
    cal_core();
    repeat (3) @(negedge mclk);
    `CHK(core_sleep, 1'b1)
    @(posedge mclk) background_calibration_enable <= 1'b0;
    repeat (3) @(negedge mclk);
    `CHK(core_sleep, 1'b0)
    $display("low-power test done");
    finish_test();
  end
endmodule : acc_regs_tb
`default_nettype wire
